// *** hw/nic_top.sv ***
// nested interrupt unit: priority resolution, cpu sequencing and ahb-lite registers
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/100ps
`include "nic_cfg.svh"

// Operation
// - four nesting levels, sixteen fixed vectors
// - reset and trap never masked
// - masking from level bits and priority registers
// - vectors FFE0h-FFFFh, address gives hardware order
// - service starts only at instruction boundary
// - stack context before taking vector
// - level bits loaded from vector priority
// - program counter loaded from vector address
// - return restores stacked level bits
// - behaves like simple non-nested scheme too
// - wait stops cpu, forces level 10
// - wait ends on interrupt or reset
// - halt wakes only on designated sources
// - priority registers read/write, reset FFh
module nic_top import nic_pkg::*; #(
    parameter logic [`NIC_NVEC-1:0] HALT_WAKE = `NIC_HALT_WAKE
) (
    // clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    // request sources
    input  wire logic [`NIC_NVEC-1:0]  irq_req,
    input  wire logic [`NIC_NPIN-1:0]  pin_in,
    // cpu core sequencer
    input  wire logic                  instr_end,
    input  wire logic                  trap_op,
    input  wire logic                  wait_for_event_op,
    input  wire logic                  halt_op,
    input  wire logic                  return_from_handler_op,
    input  wire logic [1:0]            popped_level,
    input  wire logic                  stack_done,
    output logic                       stack_req,
    output logic                       vec_load,
    output logic [15:0]                vec_addr,
    output logic [1:0]                 level_bits,
    output logic                       cpu_stop,
    // interrupt to system
    output logic                       irq
);

    // ************************************************************
    // state and per-entry helpers
    // ************************************************************

    nic_regs_s              s_q;        // registered state
    nic_regs_s              s_d;        // next state
    logic [`NIC_NPIN-1:0]   pin_f_d;    // filtered pin level, next
    logic [`NIC_NPIN-1:0]   pin_hit;    // active pin edge or level
    logic [`NIC_NVEC-1:0]   pend;       // all maskable requests
    logic [`NIC_NVEC-1:0]   cand;       // requests above current level
    logic [`NIC_NVEC-1:0]   cand_halt;  // candidates able to leave halt
    logic [1:0]             vrank [`NIC_NVEC];  // rank of each vector
    logic [1:0]             vfield [`NIC_NVEC]; // raw priority field
    logic [1:0]             cur_rank;   // rank of current level bits

    // pins share the first pin vector onward
    assign pend = irq_req | {{(`NIC_NVEC-`NIC_NPIN-`NIC_PIN_VEC0){1'b0}},
                             s_q.pin_pend, {`NIC_PIN_VEC0{1'b0}}};
    assign cur_rank = nic_rank(s_q.level);

    // ************************************************************
    // per pin filter and sensitivity
    // ************************************************************

    genvar gp;
    generate
        for (gp = 0; gp < `NIC_NPIN; gp++) begin : g_pin
            logic [1:0] sens;   // sensitivity code of this pin
            assign sens = s_q.pin_ctl[2*gp +: 2];
            // a change counts once the second and third stages agree
            assign pin_f_d[gp] = (s_q.pin_s2[gp] == s_q.pin_s3[gp]) ?
                                 s_q.pin_s3[gp] : s_q.pin_f[gp];
            always_comb begin
                case (sens)
                    `NIC_SENS_FALL: pin_hit[gp] = s_q.pin_f[gp] & ~pin_f_d[gp];
                    `NIC_SENS_RISE: pin_hit[gp] = ~s_q.pin_f[gp] & pin_f_d[gp];
                    `NIC_SENS_BOTH: pin_hit[gp] = s_q.pin_f[gp] ^ pin_f_d[gp];
                    default:        pin_hit[gp] = ~pin_f_d[gp];  // low level
                endcase
            end
        end
    endgenerate

    // ************************************************************
    // per vector eligibility
    // ************************************************************

    genvar gv;
    generate
        for (gv = 0; gv < `NIC_NVEC; gv++) begin : g_vec
            assign vfield[gv] = s_q.prio[gv/4][2*(gv%4) +: 2];
            assign vrank[gv]  = nic_rank(vfield[gv]);
            // only strictly higher priority interrupts the running level
            assign cand[gv] = pend[gv] && (vrank[gv] > cur_rank);
            assign cand_halt[gv] = cand[gv] & HALT_WAKE[gv];
        end
    endgenerate

    // ************************************************************
    // winner selection
    // ************************************************************

    logic [3:0] best;       // winning vector index
    logic [1:0] best_rank;  // its rank
    logic       any_cand;   // some vector may be taken
    logic       any_halt;   // some vector may leave halt

    // scanning down with >= lets the lower index, higher address, win ties
    always_comb begin
        best      = 4'h0;
        best_rank = 2'd0;
        any_cand  = |cand;
        any_halt  = |cand_halt;
        for (int i = `NIC_NVEC - 1; i >= 0; i--) begin
            if (cand[i] && (vrank[i] >= best_rank)) begin
                best      = 4'(i);
                best_rank = vrank[i];
            end
        end
    end

    // ************************************************************
    // register read mux, sampled in the address phase
    // ************************************************************

    logic [31:0] rd_mux;   // word seen by a read at haddr
    always_comb begin
        case (haddr[7:2])
            `NIC_IDX_PRIO0:  rd_mux = {24'h000000, s_q.prio[0]};
            `NIC_IDX_PRIO1:  rd_mux = {24'h000000, s_q.prio[1]};
            `NIC_IDX_PRIO2:  rd_mux = {24'h000000, s_q.prio[2]};
            `NIC_IDX_PRIO3:  rd_mux = {24'h000000, s_q.prio[3]};
            `NIC_IDX_PINCTL: rd_mux = {24'h000000, s_q.pin_ctl};
            `NIC_IDX_STAT:   rd_mux = {24'h000000, s_q.level, 2'b00, s_q.stat};
            `NIC_IDX_EN:     rd_mux = {24'h000000, 4'h0, s_q.en};
            default:         rd_mux = 32'h00000000;   // unmapped and clear
        endcase
    end

    // ************************************************************
    // next state
    // ************************************************************

    logic [`NIC_NEV-1:0]  ev;       // events of this cycle
    logic [`NIC_NEV-1:0]  clr;      // software clear of status
    logic [`NIC_NPIN-1:0] pin_ack;  // pin vector taken this cycle

    always_comb begin
        s_d      = s_q;
        ev       = '0;
        clr      = '0;
        pin_ack  = '0;
        s_d.vec_load = 1'b0;

        // three stage pin synchroniser
        s_d.pin_s1 = pin_in;
        s_d.pin_s2 = s_q.pin_s1;
        s_d.pin_s3 = s_q.pin_s2;
        s_d.pin_f  = pin_f_d;
        ev[`NIC_EV_PIN] = |pin_hit;

        // sequencer
        case (s_q.state)
            NIC_RESET: begin
                // reset is the first service and cannot be masked
                s_d.vec_addr = `NIC_VEC_RESET;
                s_d.vec_load = 1'b1;
                s_d.level    = `NIC_LVL_MASK;
                s_d.state    = NIC_IDLE;
            end
            NIC_IDLE: begin
                if (return_from_handler_op) begin
                    s_d.level = popped_level;
                end
                if (instr_end) begin
                    if (trap_op) begin
                        // trap ignores level bits
                        s_d.trap    = 1'b1;
                        s_d.new_lvl = `NIC_LVL_MASK;
                        s_d.state   = NIC_STACK;
                        ev[`NIC_EV_TRAP] = 1'b1;
                    end else if (wait_for_event_op) begin
                        s_d.level = `NIC_LVL_OPEN;
                        s_d.state = NIC_WAIT;
                    end else if (halt_op) begin
                        s_d.level = `NIC_LVL_OPEN;
                        s_d.state = NIC_HALT;
                    end else if (any_cand) begin
                        s_d.trap    = 1'b0;
                        s_d.sel     = best;
                        s_d.new_lvl = vfield[best];
                        s_d.state   = NIC_STACK;
                    end
                end
            end
            NIC_STACK: begin
                // context is pushed by the core before the vector is given
                if (stack_done) begin
                    s_d.level    = s_q.new_lvl;
                    s_d.vec_load = 1'b1;
                    s_d.vec_addr = s_q.trap ? `NIC_VEC_TRAP :
                                   16'(`NIC_VEC_FIRST - {s_q.sel, 1'b0});
                    s_d.state    = NIC_IDLE;
                    ev[`NIC_EV_SVC] = ~s_q.trap;
                    if (!s_q.trap && (s_q.sel >= 4'(`NIC_PIN_VEC0)) &&
                        (s_q.sel < 4'(`NIC_PIN_VEC0 + `NIC_NPIN))) begin
                        pin_ack[2'(s_q.sel - 4'(`NIC_PIN_VEC0))] = 1'b1;
                    end
                end
            end
            NIC_WAIT: begin
                // level is 10 here, so any request whose priority field is not 10 wakes
                s_d.level = `NIC_LVL_OPEN;
                if (any_cand) begin
                    s_d.trap    = 1'b0;
                    s_d.sel     = best;
                    s_d.new_lvl = vfield[best];
                    s_d.state   = NIC_STACK;
                    ev[`NIC_EV_WAKE] = 1'b1;
                end
            end
            NIC_HALT: begin
                if (any_halt) begin
                    s_d.trap    = 1'b0;
                    s_d.sel     = best;
                    s_d.new_lvl = vfield[best];
                    s_d.state   = NIC_STACK;
                    ev[`NIC_EV_WAKE] = 1'b1;
                end
            end
            default: s_d.state = NIC_IDLE;
        endcase

        // pin pending flags: a new edge wins over the acknowledge
        s_d.pin_pend = (s_q.pin_pend & ~pin_ack) | pin_hit;

        // ahb data phase write
        if (s_q.wr_pend) begin
            case (s_q.wr_idx)
                `NIC_IDX_PRIO0:  s_d.prio[0] = hwdata[7:0];
                `NIC_IDX_PRIO1:  s_d.prio[1] = hwdata[7:0];
                `NIC_IDX_PRIO2:  s_d.prio[2] = hwdata[7:0];
                `NIC_IDX_PRIO3:  s_d.prio[3] = hwdata[7:0];
                `NIC_IDX_PINCTL: s_d.pin_ctl = hwdata[7:0];
                `NIC_IDX_CLR:    clr = hwdata[`NIC_NEV-1:0];
                `NIC_IDX_EN:     s_d.en = hwdata[`NIC_NEV-1:0];
                default:         ;
            endcase
        end

        // sticky status, set wins over clear
        s_d.stat = (s_q.stat & ~clr) | ev;

        // ahb address phase; zero wait state slave
        s_d.wr_pend = 1'b0;
        if (hsel && hready && htrans[1]) begin
            s_d.wr_pend = hwrite;
            s_d.wr_idx  = haddr[7:2];
            s_d.rdata   = hwrite ? s_q.rdata : rd_mux;
        end
    end

    // ************************************************************
    // state register
    // ************************************************************

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q          <= '0;
            s_q.state    <= NIC_RESET;
            s_q.level    <= `NIC_LVL_MASK;
            s_q.prio     <= {4{`NIC_PRIO_RST}};
            s_q.pin_ctl  <= `NIC_PINCTL_RST;
            s_q.new_lvl  <= `NIC_LVL_MASK;
            s_q.vec_addr <= `NIC_VEC_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************

    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = s_q.rdata;
    assign stack_req  = (s_q.state == NIC_STACK);
    assign vec_load   = s_q.vec_load;
    assign vec_addr   = s_q.vec_addr;
    assign level_bits = s_q.level;
    assign cpu_stop   = (s_q.state == NIC_WAIT) || (s_q.state == NIC_HALT);
    assign irq        = |(s_q.stat & s_q.en);

    // ************************************************************
    // checks
    // ************************************************************

    logic stk_fin;    // stacking completes this cycle
    logic idle_q;     // sequencer idle
    logic trap_take;  // trap taken at a boundary
    assign stk_fin   = stack_req && stack_done;
    assign idle_q    = (s_q.state == NIC_IDLE);
    assign trap_take = idle_q && instr_end && trap_op;

    a_trap_vector: assert property (@(posedge hclk) disable iff (!hresetn)
        stk_fin && s_q.trap |=> vec_load && vec_addr == 16'hFFFC)
        else $error("trap did not vector to its fixed address");
    a_vec_range: assert property (@(posedge hclk) disable iff (!hresetn)
        vec_load |-> vec_addr >= 16'hFFE0 && !vec_addr[0])
        else $error("vector outside the top table");
    a_start_bound: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(stack_req) |-> $past(instr_end) || $past(cpu_stop))
        else $error("service started inside an instruction");
    a_stack_first: assert property (@(posedge hclk) disable iff (!hresetn)
        stk_fin |=> vec_load ##1 !vec_load)
        else $error("vector not given right after stacking");
    a_level_load: assert property (@(posedge hclk) disable iff (!hresetn)
        stk_fin |=> level_bits == $past(s_q.new_lvl))
        else $error("level bits not taken from vector priority");
    a_return_level: assert property (@(posedge hclk) disable iff (!hresetn)
        idle_q && return_from_handler_op |=> level_bits == $past(popped_level))
        else $error("return did not restore level bits");
    a_wait_open: assert property (@(posedge hclk) disable iff (!hresetn)
        idle_q && instr_end && !trap_op && wait_for_event_op
        |=> cpu_stop && level_bits == 2'b10)
        else $error("wait did not stop and open all levels");
    a_wait_wake: assert property (@(posedge hclk) disable iff (!hresetn)
        s_q.state == NIC_WAIT && |cand |=> stack_req && !cpu_stop)
        else $error("pending request did not end wait");
    a_halt_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        s_q.state == NIC_HALT && !(|(pend & HALT_WAKE)) |=> cpu_stop)
        else $error("halt left by a source without wake ability");
    a_mask_all: assert property (@(posedge hclk) disable iff (!hresetn)
        idle_q && level_bits == 2'b11 && instr_end && !trap_op |=> !stack_req)
        else $error("maskable request taken at level 11");

endmodule // nic_top

// *** inc/nic_cfg.svh ***
// nested interrupt unit: offsets, field positions, reset values, vector addresses
`ifndef NIC_CFG_SVH
`define NIC_CFG_SVH

// register indices, byte address is four times the index
`define NIC_IDX_PRIO0   6'h24
`define NIC_IDX_PRIO1   6'h25
`define NIC_IDX_PRIO2   6'h26
`define NIC_IDX_PRIO3   6'h27
`define NIC_IDX_PINCTL  6'h28
`define NIC_IDX_STAT    6'h29
`define NIC_IDX_CLR     6'h2A
`define NIC_IDX_EN      6'h2B

// reset values
`define NIC_PRIO_RST    8'hFF
`define NIC_PINCTL_RST  8'h00

// vector table at the top of memory, higher address wins ties
`define NIC_VEC_RESET   16'hFFFE
`define NIC_VEC_TRAP    16'hFFFC
`define NIC_VEC_FIRST   16'hFFFA
`define NIC_VEC_LOWEST  16'hFFE0

// maskable vectors, pin count and first pin vector
`define NIC_NVEC        14
`define NIC_NPIN        4
`define NIC_PIN_VEC0    2
`define NIC_HALT_WAKE   14'h003C

// level bit encodings
`define NIC_LVL_OPEN    2'b10
`define NIC_LVL_MASK    2'b11

// pin sensitivity codes
`define NIC_SENS_FALL   2'b00
`define NIC_SENS_RISE   2'b01
`define NIC_SENS_BOTH   2'b10

// status bit positions
`define NIC_EV_SVC      0
`define NIC_EV_TRAP     1
`define NIC_EV_WAKE     2
`define NIC_EV_PIN      3
`define NIC_NEV         4

`endif

// *** inc/nic_pkg.sv ***
// nested interrupt unit: state machine and state record types
`include "nic_cfg.svh"
package nic_pkg;

    // sequencer states, gray along idle <-> stack
    typedef enum logic [2:0] {
        NIC_RESET = 3'b000,
        NIC_IDLE  = 3'b001,
        NIC_STACK = 3'b011,
        NIC_WAIT  = 3'b111,
        NIC_HALT  = 3'b101
    } nic_state_e;

    // whole state of the unit
    typedef struct packed {
        nic_state_e                state;
        logic [1:0]                level;
        logic [3:0][7:0]           prio;
        logic [7:0]                pin_ctl;
        logic [`NIC_NEV-1:0]       stat;
        logic [`NIC_NEV-1:0]       en;
        logic [`NIC_NPIN-1:0]      pin_s1;
        logic [`NIC_NPIN-1:0]      pin_s2;
        logic [`NIC_NPIN-1:0]      pin_s3;
        logic [`NIC_NPIN-1:0]      pin_f;
        logic [`NIC_NPIN-1:0]      pin_pend;
        logic [3:0]                sel;
        logic [1:0]                new_lvl;
        logic                      trap;
        logic [15:0]               vec_addr;
        logic                      vec_load;
        logic                      wr_pend;
        logic [5:0]                wr_idx;
        logic [31:0]               rdata;
    } nic_regs_s;

    // level bits to nesting rank: 10 lowest, 11 masks all
    function automatic logic [1:0] nic_rank(input logic [1:0] l);
        case (l)
            2'b10:   nic_rank = 2'd0;
            2'b01:   nic_rank = 2'd1;
            2'b00:   nic_rank = 2'd2;
            default: nic_rank = 2'd3;
        endcase
    endfunction

endpackage

// *** verif/nic_core_model.sv ***
// core sequencer stand-in that answers the unit's context push requests
`timescale 1ns/100ps
module nic_core_model (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // push handshake
    input  wire logic stack_req,
    input  wire logic slow,
    output logic      stack_done
);
    int cnt_q; // cycles spent on the current push
    // push pc, index, accumulator and flags, then acknowledge once
    // slow mode stretches the push so the unit must hold its request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q      <= 0;
            stack_done <= 1'b0;
        end else begin
            stack_done <= 1'b0;
            if (stack_req && !stack_done) begin
                if (cnt_q >= (slow ? 4 : 0)) begin
                    stack_done <= 1'b1;
                    cnt_q      <= 0;
                end else begin
                    cnt_q <= cnt_q + 1;
                end
            end
        end
    end
endmodule // nic_core_model

// *** verif/tb_nic_top.sv ***
// self-checking bench for the nested interrupt unit
`timescale 1ns/100ps
`include "nic_cfg.svh"
module tb_nic_top;
    logic                 hclk, hresetn, hsel, hwrite, instr_end, trap_op, slow, irq;
    logic                 wait_for_event_op, halt_op, return_from_handler_op;
    logic                 hreadyout, hresp, stack_req, stack_done, vec_load, cpu_stop;
    logic [1:0]           htrans, popped_level, level_bits;
    logic [31:0]          haddr, hwdata, hrdata, r;
    logic [15:0]          vec_addr;
    logic [`NIC_NVEC-1:0] irq_req;
    logic [`NIC_NPIN-1:0] pin_in;
    int                   bad_count, n_compared;
    // one slave, so its ready is the bus ready; word transfers only
    nic_top nic_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq_req, .pin_in,
        .instr_end, .trap_op, .wait_for_event_op, .halt_op, .return_from_handler_op,
        .popped_level, .stack_done, .stack_req, .vec_load, .vec_addr, .level_bits,
        .cpu_stop, .irq);
    nic_core_model nic_core_model_i (.hclk, .hresetn, .stack_req, .slow, .stack_done);
    // ****************************************
    // bus and core tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // wait for ready at a rising edge; only the watchdog ends a dead wait
    task automatic rdy;
        do begin
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
    endtask
    // single word transfer: address phase, then data phase
    task automatic ahb(input logic w, input logic [5:0] idx, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, idx, 2'b00};
        hwrite <= w;
        rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rdy();
        r = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic rd(input logic [5:0] idx, input logic [31:0] m, e, input string nm);
        ahb(1'b0, idx, 32'h0);
        chk(nm, e, r & m);
    endtask
    // one instruction boundary, with the kind of instruction that ends there
    task automatic op(input logic t, w, h);
        instr_end         <= 1'b1;
        trap_op           <= t;
        wait_for_event_op <= w;
        halt_op           <= h;
        @(posedge hclk);
        {instr_end, trap_op, wait_for_event_op, halt_op} <= 4'h0;
    endtask
    task automatic expv(input logic [15:0] a, input logic [1:0] l);
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            #1;
            k++;
        end while (vec_load !== 1'b1 && k < 40);
        chk("vec_load", 32'h1, {31'h0, vec_load});
        chk("vec_addr", {16'h0, a}, {16'h0, vec_addr});
        chk("level_bits", {30'h0, l}, {30'h0, level_bits});
    endtask
    // no push and no vector may start during n cycles
    task automatic idle(input int n);
        int k;
        k = 0;
        repeat (n) begin
            @(posedge hclk);
            #1;
            if (stack_req !== 1'b0 || vec_load !== 1'b0) k++;
        end
        chk("no service", 32'h0, k);
    endtask
    task automatic ret(input logic [1:0] l);
        return_from_handler_op <= 1'b1;
        popped_level           <= l;
        @(posedge hclk);
        return_from_handler_op <= 1'b0;
        #1;
        chk("restored level", {30'h0, l}, {30'h0, level_bits});
    endtask
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ****************************************
    // clock, watchdog and tests
    // ****************************************
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    // whole run needs well under two thousand cycles
    initial begin
        repeat (4000) @(posedge hclk);
        bad_count++;
        end_sim();
    end
    initial begin
        {hresetn, hsel, hwrite, instr_end, trap_op, slow, halt_op} = '0;
        {wait_for_event_op, return_from_handler_op, htrans, popped_level} = '0;
        {haddr, hwdata, irq_req} = '0;
        pin_in = '1; // pins idle high, falling edge is the event
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        expv(`NIC_VEC_RESET, 2'b11);
        for (int i = 0; i < 4; i++) rd(6'(`NIC_IDX_PRIO0 + i), 32'hFF, 32'hFF, "prio rst");
        rd(`NIC_IDX_PINCTL, 32'hFF, 32'h00, "pinctl rst");
        rd(6'h00, 32'hFFFFFFFF, 32'h0, "unmapped");
        ahb(1'b1, `NIC_IDX_PRIO0, 32'hF5);
        rd(`NIC_IDX_PRIO0, 32'hFF, 32'hF5, "prio0");
        irq_req[1:0] <= 2'b11;
        idle(6);
        op(1'b0, 1'b0, 1'b0);
        idle(6);
        op(1'b1, 1'b0, 1'b0);
        expv(`NIC_VEC_TRAP, 2'b11);
        ret(2'b10);
        idle(4);
        op(1'b0, 1'b0, 1'b0);
        expv(16'hFFFA, 2'b01);
        irq_req[0] <= 1'b0;
        op(1'b0, 1'b0, 1'b0);
        idle(6);
        ahb(1'b1, `NIC_IDX_PRIO0, 32'hF1);
        op(1'b0, 1'b0, 1'b0);
        expv(16'hFFF8, 2'b00);
        irq_req <= '0;
        ret(2'b01);
        op(1'b0, 1'b1, 1'b0);
        idle(3);
        chk("wait stop", 32'h6, {29'h0, cpu_stop, level_bits});
        slow       <= 1'b1;
        irq_req[0] <= 1'b1;
        expv(16'hFFFA, 2'b01);
        chk("woken", 32'h0, cpu_stop);
        irq_req[0] <= 1'b0;
        slow       <= 1'b0;
        ret(2'b10);
        rd(`NIC_IDX_STAT, 32'hF, 32'h7, "status");
        ahb(1'b1, `NIC_IDX_EN, 32'h1);
        idle(2);
        chk("irq on", 32'h1, irq);
        ahb(1'b1, `NIC_IDX_CLR, 32'hF);
        idle(2);
        chk("irq off", 32'h0, irq);
        rd(`NIC_IDX_STAT, 32'hF, 32'h0, "status clr");
        op(1'b0, 1'b0, 1'b1);
        irq_req[0] <= 1'b1;
        idle(8);
        pin_in[0] <= 1'b0;
        expv(16'hFFF6, 2'b11);
        irq_req <= '0;
        pin_in  <= '1;
        ret(2'b10);
        for (int i = 0; i < 5; i++) ahb(1'b1, 6'(`NIC_IDX_PRIO0 + i), 32'h5A ^ i);
        for (int i = 0; i < 5; i++) rd(6'(`NIC_IDX_PRIO0 + i), 32'hFF, 32'h5A ^ i, "rw");
        // pin 1 now senses a low level and feeds vector 3 at field 01
        pin_in[1] <= 1'b0;
        idle(6);
        op(1'b0, 1'b0, 1'b0);
        expv(16'hFFF4, 2'b01);
        pin_in <= '1;
        end_sim();
    end
endmodule // tb_nic_top
